// [src/crp_defs.svh]
`ifndef CRP_DEFS_SVH
`define CRP_DEFS_SVH

// Command codes of the two registers on the management port.
`define CRP_CMD_MAP       8'h26
`define CRP_CMD_PRIO      8'h27

// Reset values.
`define CRP_MAP_RST       8'hE4
`define CRP_PRIO_RST      3'h0
`define CRP_RD_IDLE       8'h00

// Field positions inside the priority register.
`define CRP_CH1_PRIO_LSB  0
`define CRP_CH2_PRIO_LSB  4
`define CRP_PRIO_W        3

// Width of one physical channel select field in the map register.
`define CRP_SEL_W         2

`endif

// [src/crp_pkg.sv]
package crp_pkg;

    // One command from the management port decoder.
    typedef struct packed {
        logic       wr;    // Write strobe, one cycle.
        logic       rd;    // Read strobe, one cycle.
        logic [7:0] code;  // Command code.
        logic [7:0] data;  // Write data byte.
    } crp_cmd_type;

    // Physical select for logical channels 4..1 of a group, index 0 is logical 1.
    typedef logic [3:0][1:0] crp_map_type;

    // Fast shutdown code with its strobe.
    typedef struct packed {
        logic       valid; // One-cycle strobe when a new code is presented.
        logic [2:0] code;  // Three-bit shutdown code.
    } crp_fs_type;

    // Register bank state as seen from the management port.
    typedef enum {
        CRP_IDLE,
        CRP_ANSWER
    } crp_rd_state_type;

endpackage

// [src/crp_prio_slot.sv]
`include "crp_defs.svh"

// One channel's three-bit shutdown priority and its fast shutdown compare.
module crp_prio_slot
(
    // Clock and resets.
    input  wire logic                   ref_clk,
    input  wire logic                   rst_b,
    input  wire logic                   pin_rst_b,
    // Register write.
    input  wire logic                   wr_en,
    input  wire logic [`CRP_PRIO_W-1:0] wr_prio,
    // Fast shutdown request.
    input  wire crp_pkg::crp_fs_type    fs,
    // Results.
    output logic      [`CRP_PRIO_W-1:0] prio,
    output logic                        turn_off
);
    import crp_pkg::*;

    // Priority store; both reset sources clear it to the highest priority.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b || !pin_rst_b)
        begin
            prio <= `CRP_PRIO_RST; // [R10]
        end
        else if (wr_en)
        begin
            prio <= wr_prio; // [R10]
        end
    end

    // A lower code is a higher priority, so a channel drops whenever the
    // presented code is not above its own setting. There is no memory of
    // earlier codes: each strobe is judged alone.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b || !pin_rst_b)
        begin
            turn_off <= 1'b0;
        end
        else
        begin
            turn_off <= fs.valid && (fs.code <= prio); // [R11] [R12]
        end
    end

    // The turn-off pulse follows a qualifying code by exactly one cycle.
    AST_FS_QUALIFY: assert property (@(posedge ref_clk) disable iff (!rst_b || !pin_rst_b)
        fs.valid && (fs.code <= prio) |=> turn_off) // [R12]
        else $error("Qualifying shutdown code did not turn the channel off.");

    // A code above the setting never turns the channel off.
    AST_FS_SPARE: assert property (@(posedge ref_clk) disable iff (!rst_b || !pin_rst_b)
        turn_off |-> $past(fs.valid) && ($past(fs.code) <= $past(prio))) // [R11]
        else $error("Channel turned off by a code of lower priority.");

endmodule // crp_prio_slot

// [src/crp_regs.sv]
// Behaviour
// [R01] Map register at code 26h, read/write byte.
// [R02] Map code 00..11 selects physical 1..4.
// [R03] Bits 7:6 logical 4 down to 1:0 logical 1.
// [R04] Same map permutes within each group.
// [R05] Map write ignored unless group channels off. The code ignores it unless all channels of both groups are off.
// [R06] Rejected write keeps previous map unchanged.
// [R07] Power-on reset loads map 1110_0100.
// [R08] Pin reset leaves the map untouched.
// [R09] Host runs detect/classify before turn-on.
// [R10] Priority register 27h, ch2 6:4, ch1 2:0.
// [R11] Lower priority code means higher priority.
// [R12] Qualifying shutdown code turns channels off together.
// [R13] Shutdown clears channel, cool-down keeps running.
// [R14] Reads return stored values, no side effects.
`include "crp_defs.svh"

module crp_regs
(
    // Clock and resets.
    input  wire logic                 ref_clk,
    input  wire logic                 rst_b,
    input  wire logic                 pin_rst_b,
    // Management port command, already decoded from the serial bus.
    input  wire crp_pkg::crp_cmd_type cmd,
    output logic                      rd_valid,
    output logic [7:0]                rd_data,
    output logic                      map_wr_rejected,
    // Channel off-mode status, bit n is physical channel n+1.
    input  wire logic [7:0]           ch_off,
    // Fast shutdown input.
    input  wire crp_pkg::crp_fs_type  fast_shutdown_input,
    // Mapping and priority results.
    output crp_pkg::crp_map_type      map_group_lo,
    output crp_pkg::crp_map_type      map_group_hi,
    output logic [`CRP_PRIO_W-1:0]    ch1_prio,
    output logic [`CRP_PRIO_W-1:0]    ch2_prio,
    output logic [1:0]                fs_clear
);
    import crp_pkg::*;

    logic [7:0]       channel_map;      // Stored mapping byte.
    logic             map_hit;          // Write addressed to the map register.
    logic             map_ok;           // All channels of both groups are off.
    logic             prio_wr;          // Write addressed to the priority register.
    crp_rd_state_type rd_state;         // Read answer state.
    logic [7:0]       next_rd_data;     // Read data selected this cycle.

    // The one map byte serves both groups, so a write affects both of them
    // and both must be idle. This is stricter than per-group checking, but
    // it never lets a powered channel change pins underneath itself.
    assign map_hit = cmd.wr && (cmd.code == `CRP_CMD_MAP); // [R01]
    assign map_ok  = &ch_off; // [R05]
    assign prio_wr = cmd.wr && (cmd.code == `CRP_CMD_PRIO); // [R10]

    // Mapping store. Only the power-on reset restores the identity map; the
    // pin reset is deliberately not looked at here.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            channel_map <= `CRP_MAP_RST; // [R07] [R08]
        end
        else if (map_hit && map_ok)
        begin
            channel_map <= cmd.data; // [R01] [R05] [R06]
        end
    end

    // Rejection flag pulses for one cycle so software tooling can see it.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            map_wr_rejected <= 1'b0;
        end
        else
        begin
            map_wr_rejected <= map_hit && !map_ok; // [R05]
        end
    end

    // Field split: two bits per logical channel, logical 1 in the low pair.
    // The code value itself is the physical index minus one within a group.
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            map_group_lo[i] = channel_map[i*`CRP_SEL_W +: `CRP_SEL_W]; // [R02] [R03]
        end
        map_group_hi = map_group_lo; // [R04]
    end

    // Per-channel priority with fast shutdown compare.
    crp_prio_slot u_slot_ch1
    (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .pin_rst_b (pin_rst_b),
        .wr_en     (prio_wr),
        .wr_prio   (cmd.data[`CRP_CH1_PRIO_LSB +: `CRP_PRIO_W]),
        .fs        (fast_shutdown_input),
        .prio      (ch1_prio),
        .turn_off  (fs_clear[0])
    );

    crp_prio_slot u_slot_ch2
    (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .pin_rst_b (pin_rst_b),
        .wr_en     (prio_wr),
        .wr_prio   (cmd.data[`CRP_CH2_PRIO_LSB +: `CRP_PRIO_W]),
        .fs        (fast_shutdown_input),
        .prio      (ch2_prio),
        .turn_off  (fs_clear[1])
    );

    // The fs_clear pulses ask the channel logic for the same clearing a
    // channel reset does, but they are separate from the reset command so
    // that the fault cool-down timer is left running. [R13]

    // Read mux. Reserved bits 7 and 3 of the priority register are not
    // stored and read as zero; unknown codes read as zero.
    always_comb
    begin
        case (cmd.code)
            `CRP_CMD_MAP:
            begin
                next_rd_data = channel_map; // [R14]
            end
            `CRP_CMD_PRIO:
            begin
                next_rd_data = {1'b0, ch2_prio, 1'b0, ch1_prio}; // [R10] [R14]
            end
            default:
            begin
                next_rd_data = `CRP_RD_IDLE;
            end
        endcase
    end

    // Read answer state: a read is answered on the following cycle.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            rd_state <= CRP_IDLE;
        end
        else
        begin
            case (rd_state)
                CRP_IDLE:
                begin
                    rd_state <= cmd.rd ? CRP_ANSWER : CRP_IDLE;
                end
                CRP_ANSWER:
                begin
                    rd_state <= cmd.rd ? CRP_ANSWER : CRP_IDLE;
                end
                default:
                begin
                    rd_state <= CRP_IDLE;
                end
            endcase
        end
    end

    assign rd_valid = (rd_state == CRP_ANSWER);

    // Read data register; holds its last value between reads.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            rd_data <= `CRP_RD_IDLE;
        end
        else if (cmd.rd)
        begin
            rd_data <= next_rd_data; // [R14]
        end
    end

    // Accepted map write is stored exactly on the next edge.
    AST_MAP_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cmd.wr && cmd.code == `CRP_CMD_MAP && (&ch_off)
        |=> channel_map == $past(cmd.data)) // [R01]
        else $error("Accepted map write not stored.");

    // A map write with any channel on leaves the map as it was.
    AST_MAP_REJECT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cmd.wr && cmd.code == `CRP_CMD_MAP && !(&ch_off)
        |=> $stable(channel_map) && map_wr_rejected) // [R05]
        else $error("Rejected map write changed the map.");

    // The map changes only through an accepted write. The edge right after a
    // power-on reset is left out, since the reset itself reloads the map then.
    AST_MAP_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $past(rst_b) && !$stable(channel_map)
        |-> $past(cmd.wr) && $past(cmd.code) == `CRP_CMD_MAP
        && (&$past(ch_off))) // [R06]
        else $error("Map changed without an accepted write.");

    // Power-on reset gives the identity map right after release.
    AST_MAP_POR: assert property (@(posedge ref_clk)
        !rst_b |=> channel_map == `CRP_MAP_RST) // [R07]
        else $error("Map not at identity after power-on reset.");

    // Pin reset alone never alters the map.
    AST_MAP_PIN: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !pin_rst_b && !(cmd.wr && cmd.code == `CRP_CMD_MAP) |=> $stable(channel_map)) // [R08]
        else $error("Pin reset disturbed the map.");

    // Logical 4 sits in the top pair and both groups see the same map.
    AST_MAP_FIELDS: assert property (@(posedge ref_clk) disable iff (!rst_b)
        map_group_lo[3] == channel_map[7:6] && map_group_lo[0] == channel_map[1:0]
        && map_group_hi == map_group_lo) // [R03]
        else $error("Map fields misplaced.");

    // Priority write lands in the right fields on the next edge.
    AST_PRIO_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b || !pin_rst_b)
        cmd.wr && cmd.code == `CRP_CMD_PRIO
        |=> ch2_prio == $past(cmd.data[6:4]) && ch1_prio == $past(cmd.data[2:0])) // [R10]
        else $error("Priority write misplaced.");

    // A map read answers one cycle later with the stored value and no side effect.
    AST_READ_BACK: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cmd.rd && !cmd.wr && cmd.code == `CRP_CMD_MAP
        |=> rd_valid && rd_data == channel_map) // [R14]
        else $error("Map read did not return the stored value.");

    // Channels sharing a setting drop together.
    AST_FS_TOGETHER: assert property (@(posedge ref_clk) disable iff (!rst_b || !pin_rst_b)
        ch1_prio == ch2_prio && fast_shutdown_input.valid |=> fs_clear[0] == fs_clear[1]) // [R12]
        else $error("Channels with equal priority did not drop together.");

endmodule // crp_regs

// [sim/crp_host.sv]
// Host side of the management port: one command byte per call.
module crp_host
(
    // Clock.
    input  wire logic            ref_clk,
    // Decoded command towards the register bank.
    output crp_pkg::crp_cmd_type cmd
);
    timeunit 1ns;
    timeprecision 100ps;
    import crp_pkg::*;

    initial cmd = '0;

    // One strobe for one cycle, set and dropped on falling edges.
    // Callers put the whole group in off mode before a good map write.
    // This host never turns a channel on after a remap, as one that first runs
    // a detection and classification cycle would not do so early either.
    // Released code and data lines flip so a stale value is never read as valid.
    task automatic send(input logic wr, input logic [7:0] code, input logic [7:0] data);
        @(negedge ref_clk);
        cmd <= {wr, ~wr, code, data};
        @(negedge ref_clk);
        cmd <= {2'b00, ~code, ~data};
    endtask
endmodule // crp_host

// [sim/test_channel_remap_priority_regs.sv]
module test_channel_remap_priority_regs;
    timeunit 1ns;
    timeprecision 100ps;
    import crp_pkg::*;

    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        pin_rst_b = 1'b1;
    logic [7:0]  ch_off = 8'hff;
    crp_fs_type  fsi = '0;
    crp_cmd_type cmd;
    logic        rd_valid;
    logic        rej;
    logic [7:0]  rd_data;
    crp_map_type mlo;
    crp_map_type mhi;
    logic [2:0]  p1;
    logic [2:0]  p2;
    logic [1:0]  fs_clear;
    // Model state: map byte and the two priorities.
    int          n_mismatch = 0;
    int          compares = 0;
    int          map_m = 'he4;
    int          pr1 = 0;
    int          pr2 = 0;
    logic [7:0]  v;

    always #12.5 ref_clk = ~ref_clk;

    crp_host host (.ref_clk(ref_clk), .cmd(cmd));

    crp_regs dut
    (
        .ref_clk(ref_clk), .rst_b(rst_b), .pin_rst_b(pin_rst_b), .cmd(cmd),
        .rd_valid(rd_valid), .rd_data(rd_data), .map_wr_rejected(rej), .ch_off(ch_off),
        .fast_shutdown_input(fsi), .map_group_lo(mlo), .map_group_hi(mhi),
        .ch1_prio(p1), .ch2_prio(p2), .fs_clear(fs_clear)
    );

    // Compares one value and counts it.
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // Read answers one cycle after the strobe, which is where send returns.
    task automatic rd_chk(input logic [7:0] code, input logic [7:0] exp);
        host.send(1'b0, code, 8'h00);
        chk("rd_valid", 8'h01, {7'd0, rd_valid});
        chk("rd_data", exp, rd_data);
    endtask

    // Packed map outputs share the register's bit layout.
    task automatic map_chk();
        chk("map_group_lo", map_m[7:0], mlo);
        chk("map_group_hi", map_m[7:0], mhi);
    endtask

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Hang guard: a run that never ends counts as a mismatch.
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        print_verdict();
    end

    initial
    begin
        void'($urandom(28314));
        repeat (5) @(negedge ref_clk);
        rst_b = 1'b1;
        rd_chk(8'h26, 8'he4);
        rd_chk(8'h27, 8'h00);
        rd_chk(8'h28, 8'h00);
        map_chk();
        $display("test reset values done");
        // Accepted map writes with every channel off.
        repeat (6)
        begin
            v = 8'($urandom);
            host.send(1'b1, 8'h26, v);
            map_m = v;
            chk("rejected", 8'h00, {7'd0, rej});
            map_chk();
            rd_chk(8'h26, map_m[7:0]);
        end
        $display("test map write done");
        // One channel left on: the write must bounce and the map hold.
        repeat (4)
        begin
            @(negedge ref_clk);
            ch_off = 8'hff ^ (8'h01 << $urandom_range(7));
            host.send(1'b1, 8'h26, ~map_m[7:0]);
            chk("rejected", 8'h01, {7'd0, rej});
            map_chk();
        end
        ch_off = 8'hff;
        $display("test map refusal done");
        // Priorities, then every shutdown code against them; odd rounds share one setting.
        for (int i = 0; i < 8; i++)
        begin
            v = 8'($urandom);
            if (i % 2)
                v[6:4] = v[2:0];
            host.send(1'b1, 8'h27, v);
            pr1 = v[2:0];
            pr2 = v[6:4];
            rd_chk(8'h27, 8'(pr2 * 16 + pr1));
            chk("ch1_prio", 8'(pr1), {5'd0, p1});
            chk("ch2_prio", 8'(pr2), {5'd0, p2});
            for (int c = 0; c < 8; c++)
            begin
                @(negedge ref_clk);
                fsi = {1'b1, 3'(c)};
                @(negedge ref_clk);
                fsi.valid = 1'b0;
                chk("fs_clear", {6'd0, c <= pr2, c <= pr1}, {6'd0, fs_clear});
            end
        end
        $display("test priority and shutdown done");
        // Pin reset keeps the map; power-on reset restores it.
        @(negedge ref_clk);
        pin_rst_b = 1'b0;
        @(negedge ref_clk);
        pin_rst_b = 1'b1;
        map_chk();
        rd_chk(8'h26, map_m[7:0]);
        pr1 = 0;
        pr2 = 0;
        chk("ch1_prio", 8'(pr1), {5'd0, p1});
        chk("ch2_prio", 8'(pr2), {5'd0, p2});
        @(negedge ref_clk);
        rst_b = 1'b0;
        @(negedge ref_clk);
        rst_b = 1'b1;
        map_m = 'he4;
        map_chk();
        rd_chk(8'h26, map_m[7:0]);
        rd_chk(8'h27, 8'h00);
        $display("test resets done");
        print_verdict();
    end
endmodule // test_channel_remap_priority_regs
